//--- src/readback_pkg.sv
package readback_pkg;

  // Read addresses selected by the host on the serial control bus.
  localparam logic [7:0] ADDR_DETECT = 8'hEA;
  localparam logic [7:0] ADDR_PINS_RATE = 8'hEB;
  localparam logic [7:0] ADDR_CHANSTAT = 8'hEC;
  localparam logic [7:0] ADDR_PREAMBLE = 8'hED;

  // Word lengths; the hold register is as long as the longest word.
  localparam int ADDR_BITS = 8;
  localparam int WORD_BITS = 48;
  localparam int DETECT_BITS = 24;
  localparam int PINS_RATE_BITS = 8;
  localparam int PREAMBLE_BITS = 16;
  localparam int NUM_INPUTS = 7;
  localparam int NUM_PINS = 4;
  localparam int RATE_BITS = 4;

  // Field positions in the detection and flag word.
  localparam int POS_PRESENT = 0;
  localparam int POS_ERROR = 8;
  localparam int POS_INPUT_CHG = 9;
  localparam int POS_RATE_UPD = 10;
  localparam int POS_CS_UPD = 11;
  localparam int POS_NONLINEAR = 12;
  localparam int POS_PC_UPD = 13;
  localparam int POS_PIN_CHG = 14;
  localparam int POS_EMPHASIS = 15;
  localparam int POS_MARKER = 16;
  localparam int POS_BURST = 17;
  localparam int POS_SURROUND = 18;
  localparam int POS_EXT_SURROUND = 19;

  // Field positions in the pin level and rate code word.
  localparam int POS_PIN_LEVEL = 0;
  localparam int POS_RATE_CODE = 4;

  // Reset values.
  localparam logic [WORD_BITS-1:0] WORD_RESET = 48'h0000_0000_0000;
  localparam logic [PREAMBLE_BITS-1:0] PREAMBLE_RESET = 16'h0000;
  localparam logic [NUM_INPUTS-1:0] PRESENT_RESET = 7'h00;
  localparam logic [NUM_PINS-1:0] PIN_RESET = 4'h0;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // Function select value meaning parallel input on the general-purpose pins.
  localparam logic PIN_SELECT_PARALLEL = 1'b0;

  // Timing: the pin inputs are sampled at a fixed rate for change detection.
  localparam int CLK_HZ = 20_000_000;
  localparam int PIN_SAMPLE_HZ = 24_000;
  localparam int PIN_SAMPLE_CYCLES = CLK_HZ / PIN_SAMPLE_HZ;
  localparam int SAMPLE_CNT_BITS = 10;

  // Link-side phases of one bus frame; Gray-coded along the usual path.
  typedef enum logic [1:0] {
    LINK_ADDR = 2'b00,
    LINK_WAIT = 2'b01,
    LINK_SHIFT = 2'b11
  } link_state_t;

endpackage

//--- src/bit_sync2.sv
`timescale 1ns/10ps
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // bit_sync2

//--- src/receiver_readback_registers.sv
`timescale 1ns/10ps
// Functional notes
// [R01] Four read addresses: detection/flags, pin levels plus rate, channel status, preamble.
// [R02] Detection bits 0-6 show data present per input; bit 7 reads 0.
// [R03] Host enables input monitoring before trusting the detection bits.
// [R04] Bit 8 shows live error: transfer error or PLL unlocked.
// [R05] Input, rate, channel-status and preamble update flags latch and clear on read.
// [R06] Bit 14 latches pin sample changes in parallel input mode; clears on read.
// [R07] Bit 12 shows live non-PCM detection.
// [R08] Bit 15 shows live emphasis indication.
// [R09] Error and non-PCM bits follow error content select, independent of interrupt setup; only bit 8 uses the select, bit 12 stays live.
// [R10] Bit 16 shows received channel-status bit 1.
// [R11] Bit 17 shows burst preamble detected; bits 20-23 read 0.
// [R12] Bits 18 and 19 show 5.1 and 6.1 surround sync detection.
// [R13] Second word bits 0-3 return pin levels in parallel input mode.
// [R14] Second word bits 4-7 return the measured rate code.
// [R15] Channel-status read shifts out first 48 bits, bit 0 first.
// [R16] Captured channel status freezes from address selection until the read ends.
// [R17] Channel-status bits keep the standard positions, unchanged.
// [R18] Preamble read returns the latest 16-bit Pc word on bits 0-15.
// [R19] Pin function select: 0 parallel input, 1 selector input; reset value 0.
// [R20] Detection reporting needs crystal clock selected and monitoring enabled.
// [R21] Bits clocked beyond a word's length read as 0.
module receiver_readback_registers
  import readback_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial control bus pins, sampled on the bus clock
  input wire logic bus_clk,
  input wire logic bus_ce,
  input wire logic bus_di,
  output logic bus_do,
  output logic bus_do_oe_n,
  // Configuration from the write-side registers
  input wire logic input_monitor_enable,
  input wire logic xtal_clock_selected,
  input wire logic pin_function_select,
  input wire logic error_content_select,
  // Live receiver status
  input wire logic pll_unlocked,
  input wire logic transfer_error,
  input wire logic nonlinear_audio_status,
  input wire logic emphasis_status,
  input wire logic nonlinear_marker_bit,
  input wire logic burst_sync_detected,
  input wire logic surround_sync_detected,
  input wire logic extended_surround_sync_detected,
  input wire logic [NUM_INPUTS-1:0] input_present_bits,
  // Rate measurement
  input wire logic [RATE_BITS-1:0] rate_code,
  input wire logic rate_calc_done,
  // Channel status and preamble blocks from the demodulator
  input wire logic [WORD_BITS-1:0] chanstat_block,
  input wire logic chanstat_valid,
  input wire logic [PREAMBLE_BITS-1:0] preamble_word,
  input wire logic preamble_valid,
  // General-purpose pins
  input wire logic [NUM_PINS-1:0] pin_in,
  // Status seen by the rest of the chip
  output logic chanstat_frozen,
  output logic [PREAMBLE_BITS-1:0] preamble_latest
);

  // ---------------------------------------------------------------
  // Core domain
  // ---------------------------------------------------------------

  logic [NUM_PINS-1:0] pin_level_bits;
  logic ce_sync;
  logic req_sync;
  logic req_seen_reg;
  logic ack_reg;
  logic new_req;
  logic [WORD_BITS-1:0] hold_reg;
  logic [WORD_BITS-1:0] cs_capture_reg;
  logic [WORD_BITS-1:0] cs_last_reg;
  logic [PREAMBLE_BITS-1:0] pc_last_reg;
  logic [NUM_INPUTS-1:0] present_prev_reg;
  logic [NUM_PINS-1:0] pin_sample_reg;
  logic [SAMPLE_CNT_BITS-1:0] sample_cnt_reg;
  logic sample_tick;
  logic saw_ce_high_reg;
  logic input_change_flag;
  logic rate_update_flag;
  logic chanstat_update_flag;
  logic preamble_update_flag;
  logic pin_input_change_flag;
  logic detect_active;
  logic live_error_status;
  logic [NUM_INPUTS-1:0] present_masked;
  logic read_flags;
  logic [ADDR_BITS-1:0] link_addr_reg;
  logic req_tgl_reg;

  bit_sync2 #(
    .WIDTH(NUM_PINS + 2)
  ) u_core_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({pin_in, bus_ce, req_tgl_reg}),
    .sync_out({pin_level_bits, ce_sync, req_sync})
  );

  assign new_req = req_sync ^ req_seen_reg;
  assign read_flags = new_req && (link_addr_reg == ADDR_DETECT);

  // Detection is only meaningful on the crystal clock with monitoring on.
  assign detect_active = input_monitor_enable & xtal_clock_selected; // [R20] [R03]
  assign present_masked = detect_active ? input_present_bits : PRESENT_RESET; // [R02]

  // Error content optionally folds in non-PCM detection.
  assign live_error_status = pll_unlocked | transfer_error |
                             (error_content_select & nonlinear_audio_status); // [R04] [R09]

  // Assemble the selected word, zero-padded to the hold width.
  function automatic logic [WORD_BITS-1:0] build_word(input logic [ADDR_BITS-1:0] addr);
    logic [WORD_BITS-1:0] w;
    w = WORD_RESET; // [R21]
    case (addr)
      ADDR_DETECT: begin
        w[POS_PRESENT +: NUM_INPUTS] = present_masked; // [R02]
        w[POS_ERROR] = live_error_status; // [R04]
        w[POS_INPUT_CHG] = input_change_flag; // [R05]
        w[POS_RATE_UPD] = rate_update_flag; // [R05]
        w[POS_CS_UPD] = chanstat_update_flag; // [R05]
        w[POS_NONLINEAR] = nonlinear_audio_status; // [R07] [R09]
        w[POS_PC_UPD] = preamble_update_flag; // [R05]
        w[POS_PIN_CHG] = pin_input_change_flag; // [R06]
        w[POS_EMPHASIS] = emphasis_status; // [R08]
        w[POS_MARKER] = nonlinear_marker_bit; // [R10]
        w[POS_BURST] = burst_sync_detected; // [R11]
        w[POS_SURROUND] = surround_sync_detected; // [R12]
        w[POS_EXT_SURROUND] = extended_surround_sync_detected; // [R12]
      end
      ADDR_PINS_RATE: begin
        if (pin_function_select == PIN_SELECT_PARALLEL) begin
          w[POS_PIN_LEVEL +: NUM_PINS] = pin_level_bits; // [R13] [R19]
        end
        w[POS_RATE_CODE +: RATE_BITS] = rate_code; // [R14]
      end
      ADDR_CHANSTAT: begin
        w = cs_capture_reg; // [R15] [R17]
      end
      ADDR_PREAMBLE: begin
        w[PREAMBLE_BITS-1:0] = pc_last_reg; // [R18]
      end
      default: begin
        w = WORD_RESET;
      end
    endcase
    return w;
  endfunction

  // Request handshake: snapshot the word, then acknowledge by toggle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_seen_reg <= 1'b0;
      ack_reg <= 1'b0;
      hold_reg <= WORD_RESET;
    end else if (new_req) begin
      req_seen_reg <= req_sync;
      ack_reg <= ~ack_reg;
      hold_reg <= build_word(link_addr_reg); // [R01]
    end
  end

  // Freeze runs from address selection until the bus enable falls after the read.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chanstat_frozen <= 1'b0;
      saw_ce_high_reg <= 1'b0;
    end else if (new_req && (link_addr_reg == ADDR_CHANSTAT)) begin
      chanstat_frozen <= 1'b1; // [R16]
      saw_ce_high_reg <= 1'b0;
    end else if (chanstat_frozen && ce_sync) begin
      saw_ce_high_reg <= 1'b1;
    end else if (saw_ce_high_reg && !ce_sync) begin
      chanstat_frozen <= 1'b0; // [R16]
      saw_ce_high_reg <= 1'b0;
    end
  end

  // A block counts as updated only when it repeats the previous one.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_last_reg <= WORD_RESET;
      cs_capture_reg <= WORD_RESET;
    end else if (chanstat_valid) begin
      cs_last_reg <= chanstat_block;
      if ((chanstat_block == cs_last_reg) && !chanstat_frozen) begin
        cs_capture_reg <= chanstat_block; // [R16]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_last_reg <= PREAMBLE_RESET;
    end else if (preamble_valid) begin
      pc_last_reg <= preamble_word; // [R18]
    end
  end

  assign preamble_latest = pc_last_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      present_prev_reg <= PRESENT_RESET;
    end else begin
      present_prev_reg <= present_masked;
    end
  end

  // Pin change detection works on samples at a slow fixed rate, so pin
  // bounce between samples does not raise the flag.
  assign sample_tick = (sample_cnt_reg == SAMPLE_CNT_BITS'(PIN_SAMPLE_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_cnt_reg <= '0;
    end else if (sample_tick) begin
      sample_cnt_reg <= '0;
    end else begin
      sample_cnt_reg <= sample_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sample_reg <= PIN_RESET;
    end else if (sample_tick && (pin_function_select == PIN_SELECT_PARALLEL)) begin
      pin_sample_reg <= pin_level_bits; // [R06]
    end
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_change_flag <= 1'b0;
      rate_update_flag <= 1'b0;
      chanstat_update_flag <= 1'b0;
      preamble_update_flag <= 1'b0;
      pin_input_change_flag <= 1'b0;
    end else begin
      input_change_flag <= (input_change_flag & ~read_flags) |
                           (present_masked != present_prev_reg); // [R05]
      rate_update_flag <= (rate_update_flag & ~read_flags) | rate_calc_done; // [R05]
      chanstat_update_flag <= (chanstat_update_flag & ~read_flags) |
                              (chanstat_valid && (chanstat_block == cs_last_reg)); // [R05]
      preamble_update_flag <= (preamble_update_flag & ~read_flags) |
                              (preamble_valid && (preamble_word == pc_last_reg)); // [R05]
      pin_input_change_flag <= (pin_input_change_flag & ~read_flags) |
                               (sample_tick && (pin_function_select == PIN_SELECT_PARALLEL) &&
                                (pin_level_bits != pin_sample_reg)); // [R06]
    end
  end

  // ---------------------------------------------------------------
  // Link domain, on the host's bus clock
  // ---------------------------------------------------------------

  link_state_t link_state_reg;
  logic [ADDR_BITS-1:0] addr_shift_reg;
  logic [3:0] addr_cnt_reg;
  logic [3:0] addr_cnt_now;
  logic [ADDR_BITS-1:0] addr_full;
  logic [5:0] bit_cnt_reg;
  logic read_valid_reg;
  logic ack_sync;
  logic ack_done;

  bit_sync2 #(
    .WIDTH(1)
  ) u_link_sync (
    .clk(bus_clk),
    .reset_n(reset_n),
    .async_in(ack_reg),
    .sync_out(ack_sync)
  );

  assign addr_cnt_now = (link_state_reg == LINK_ADDR) ? addr_cnt_reg : 4'h0;
  assign addr_full = {bus_di, addr_shift_reg[ADDR_BITS-1:1]};
  assign ack_done = (ack_sync == req_tgl_reg);

  // The pin is released unless a valid read address owns this frame.
  assign bus_do_oe_n = ~(bus_ce & read_valid_reg);

  // Address bits arrive least significant first while the enable is low.
  always_ff @(posedge bus_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_state_reg <= LINK_ADDR;
      addr_shift_reg <= ADDR_RESET;
      addr_cnt_reg <= 4'h0;
      link_addr_reg <= ADDR_RESET;
      req_tgl_reg <= 1'b0;
      read_valid_reg <= 1'b0;
    end else if (!bus_ce) begin
      link_state_reg <= LINK_ADDR;
      addr_shift_reg <= addr_full;
      if (addr_cnt_now != 4'hF) begin
        addr_cnt_reg <= addr_cnt_now + 4'h1;
      end
      if (addr_cnt_now == 4'h0) begin
        read_valid_reg <= 1'b0;
      end
      if (addr_cnt_now == 4'(ADDR_BITS - 1)) begin
        if ((addr_full == ADDR_DETECT) || (addr_full == ADDR_PINS_RATE) ||
            (addr_full == ADDR_CHANSTAT) || (addr_full == ADDR_PREAMBLE)) begin
          link_addr_reg <= addr_full; // [R01]
          req_tgl_reg <= ~req_tgl_reg;
          read_valid_reg <= 1'b1;
        end
      end
    end else begin
      case (link_state_reg)
        LINK_ADDR: begin
          link_state_reg <= LINK_WAIT;
        end
        LINK_WAIT: begin
          if (ack_done && read_valid_reg) begin
            link_state_reg <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          link_state_reg <= LINK_SHIFT;
        end
        default: begin
          link_state_reg <= LINK_ADDR;
        end
      endcase
    end
  end

  // Data leaves least significant first; the hold register stays still
  // until the next request, so it is safe to read here once acknowledged.
  always_ff @(posedge bus_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg <= '0;
      bus_do <= 1'b0;
    end else if (!bus_ce || (link_state_reg == LINK_ADDR)) begin
      bit_cnt_reg <= '0;
      bus_do <= 1'b0;
    end else if (ack_done && read_valid_reg) begin
      if (bit_cnt_reg < 6'(WORD_BITS)) begin
        bus_do <= hold_reg[bit_cnt_reg]; // [R15]
        bit_cnt_reg <= bit_cnt_reg + 6'h1;
      end else begin
        bus_do <= 1'b0; // [R21]
      end
    end
  end

endmodule // receiver_readback_registers

//--- bench/readback_checker_sva.sv
`timescale 1ns/10ps
module readback_checker
  import readback_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_clk,
  // Serial bus pins
  input wire logic bus_ce,
  input wire logic bus_do,
  input wire logic bus_do_oe_n,
  // Preamble and channel-status state
  input wire logic [PREAMBLE_BITS-1:0] preamble_word,
  input wire logic preamble_valid,
  input wire logic chanstat_frozen,
  input wire logic [PREAMBLE_BITS-1:0] preamble_latest
);
  // The first two read edges carry no data, so the host can settle its sampler.
  sequence lead_in_s;
    !bus_do ##1 !bus_do;
  endsequence

  // The synchroniser and the release register take a few system clocks.
  sequence freeze_release_s;
    ##[1:5] !chanstat_frozen;
  endsequence

  chk_oe_idle_off: assert property (
    @(posedge clk) disable iff (!reset_n) !bus_ce |-> bus_do_oe_n)
    else $error("output enable active outside the read phase");
  // A read phase keeps the drive decision taken at the end of the address.
  chk_oe_steady: assert property (
    @(posedge bus_clk) disable iff (!reset_n) (bus_ce && $past(bus_ce)) |-> $stable(bus_do_oe_n))
    else $error("output enable changed inside the read phase");
  chk_read_lead_in: assert property (
    @(posedge bus_clk) disable iff (!reset_n) $rose(bus_ce) |=> lead_in_s)
    else $error("data seen during the lead-in edges");
  chk_addr_quiet: assert property (
    @(posedge bus_clk) disable iff (!reset_n) (!bus_ce && $past(!bus_ce)) |-> !bus_do)
    else $error("data line not low during the address phase");
  chk_pc_capture: assert property (
    @(posedge clk) disable iff (!reset_n)
    preamble_valid |=> preamble_latest == $past(preamble_word))
    else $error("preamble word not captured");
  chk_pc_hold: assert property (
    @(posedge clk) disable iff (!reset_n) !preamble_valid |=> $stable(preamble_latest))
    else $error("preamble word changed without a strobe");
  chk_freeze_start: assert property (
    @(posedge clk) disable iff (!reset_n) $rose(chanstat_frozen) |-> !bus_ce)
    else $error("freeze began outside the address phase");
  chk_freeze_hold: assert property (
    @(posedge clk) disable iff (!reset_n) (chanstat_frozen && bus_ce) |=> chanstat_frozen)
    else $error("freeze released during the read phase");
  chk_freeze_end: assert property (
    @(posedge clk) disable iff (!reset_n)
    ($fell(bus_ce) && chanstat_frozen) |-> freeze_release_s)
    else $error("freeze not released after the frame");
endmodule // readback_checker

bind receiver_readback_registers readback_checker readback_checker_i (
  .clk(clk),
  .reset_n(reset_n),
  .bus_clk(bus_clk),
  .bus_ce(bus_ce),
  .bus_do(bus_do),
  .bus_do_oe_n(bus_do_oe_n),
  .preamble_word(preamble_word),
  .preamble_valid(preamble_valid),
  .chanstat_frozen(chanstat_frozen),
  .preamble_latest(preamble_latest)
);

//--- bench/host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model (
  // Bus pins driven by the host
  output logic bus_clk,
  output logic bus_ce,
  output logic bus_di,
  // Bus pins driven by the device
  input wire logic bus_do,
  input wire logic bus_do_oe_n
);
  initial begin
    bus_clk = 1'b0;
    bus_ce = 1'b0;
    bus_di = 1'b0;
  end

  // The bus clock stands still between frames; 12 ns period inside them.
  task automatic read_word(input logic [7:0] addr, input int n, output logic [51:0] data,
                           output logic oe_n);
    data = 52'h0;
    for (int i = 0; i < 8; i++) begin
      bus_di = addr[i];
      #6 bus_clk = 1'b1;
      #6 bus_clk = 1'b0;
    end
    // Data in is unused after the address, so it must not look stable.
    bus_di = ~bus_di;
    #600 bus_ce = 1'b1;
    #6 oe_n = bus_do_oe_n;
    for (int j = 1; j <= n + 2; j++) begin
      bus_clk = 1'b1;
      #6 bus_clk = 1'b0;
      // No pull is fitted, so a released line shows the inverse of the last level.
      if (j >= 3) data[j-3] = bus_do_oe_n ? ~bus_do : bus_do;
      #6;
    end
    bus_ce = 1'b0;
    #60;
  endtask
endmodule // host_bus_model

//--- bench/receiver_readback_registers_bench.sv
`timescale 1ns/10ps
module receiver_readback_registers_bench;
  import readback_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_clk, bus_ce, bus_di, bus_do, bus_do_oe_n, chanstat_frozen;
  logic input_monitor_enable, xtal_clock_selected, pin_function_select, error_content_select;
  logic pll_unlocked, transfer_error, nonlinear_audio_status, emphasis_status;
  logic nonlinear_marker_bit, burst_sync_detected, surround_sync_detected;
  logic extended_surround_sync_detected, rate_calc_done, chanstat_valid, preamble_valid;
  logic [NUM_INPUTS-1:0] input_present_bits;
  logic [RATE_BITS-1:0] rate_code;
  logic [WORD_BITS-1:0] chanstat_block;
  logic [PREAMBLE_BITS-1:0] preamble_word, preamble_latest;
  logic [NUM_PINS-1:0] pin_in;
  logic [10:0] ctl [6];
  logic [23:0] det_exp [6];
  int checks = 0;
  int n_mismatch = 0;

  always #25 clk = ~clk;

  receiver_readback_registers receiver_readback_registers_i (.clk, .reset_n, .bus_clk,
    .bus_ce, .bus_di, .bus_do, .bus_do_oe_n, .input_monitor_enable, .xtal_clock_selected,
    .pin_function_select, .error_content_select, .pll_unlocked, .transfer_error,
    .nonlinear_audio_status, .emphasis_status, .nonlinear_marker_bit, .burst_sync_detected,
    .surround_sync_detected, .extended_surround_sync_detected, .input_present_bits,
    .rate_code, .rate_calc_done, .chanstat_block, .chanstat_valid, .preamble_word,
    .preamble_valid, .pin_in, .chanstat_frozen, .preamble_latest);

  host_bus_model host_bus_model_i (.bus_clk, .bus_ce, .bus_di, .bus_do, .bus_do_oe_n);

  task automatic check(input string name, input logic [51:0] exp, input logic [51:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Four extra bits are clocked so the zero padding is checked on every mapped word.
  task automatic rd(input logic [7:0] addr, input int n, input logic [51:0] exp,
                    input string name);
    logic [51:0] d;
    logic oe_n;
    host_bus_model_i.read_word(addr, n + 4, d, oe_n);
    check(name, exp, d);
    check("output enable", {51'h0, n == 0}, {51'h0, oe_n});
  endtask

  // A block counts only once seen twice in a row, so each is strobed twice.
  task automatic send(input logic [47:0] b, input logic [15:0] p);
    repeat (2) begin
      @(posedge clk);
      #2 chanstat_block = b;
      preamble_word = p;
      chanstat_valid = 1'b1;
      preamble_valid = 1'b1;
      @(posedge clk);
      #2 chanstat_valid = 1'b0;
      preamble_valid = 1'b0;
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #2ms n_mismatch++;
    summarize();
  end

  initial begin
    {input_monitor_enable, xtal_clock_selected, error_content_select, pll_unlocked,
     transfer_error, nonlinear_audio_status, emphasis_status, nonlinear_marker_bit,
     burst_sync_detected, surround_sync_detected, extended_surround_sync_detected} = 11'h000;
    {pin_function_select, rate_calc_done, chanstat_valid, preamble_valid} = 4'h0;
    input_present_bits = 7'h55;
    rate_code = 4'h0;
    pin_in = 4'h0;
    chanstat_block = 48'h0;
    preamble_word = 16'h0;
    // Monitoring is enabled in the first step, before any detection read.
    ctl = '{11'h600, 11'h600, 11'h6BF, 11'h640, 11'h720, 11'h320};
    det_exp = '{24'h00_0255, 24'h00_0055, 24'h0F_9155, 24'h00_0155, 24'h00_1155, 24'h00_1300};
    repeat (3) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #2 {input_monitor_enable, xtal_clock_selected, error_content_select, pll_unlocked,
          transfer_error, nonlinear_audio_status, emphasis_status, nonlinear_marker_bit,
          burst_sync_detected, surround_sync_detected, extended_surround_sync_detected} = ctl[i];
      repeat (20) @(posedge clk);
      rd(ADDR_DETECT, DETECT_BITS, 52'(det_exp[i]), "detect");
    end
    $display("test detection done");
    @(posedge clk);
    #2 rate_code = 4'hC;
    pin_in = 4'hA;
    rate_calc_done = 1'b1;
    @(posedge clk);
    #2 rate_calc_done = 1'b0;
    repeat (2 * PIN_SAMPLE_CYCLES + 10) @(posedge clk);
    rd(ADDR_DETECT, DETECT_BITS, 52'h5500, "event flags");
    rd(ADDR_DETECT, DETECT_BITS, 52'h1100, "flags cleared");
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      #2 rate_code = c[3:0];
      rd(ADDR_PINS_RATE, PINS_RATE_BITS, {44'h0, c[3:0], 4'hA}, "pins and rate");
    end
    @(posedge clk);
    #2 pin_function_select = 1'b1;
    rd(ADDR_PINS_RATE, PINS_RATE_BITS, 52'hF0, "selector mode");
    rd(8'hEE, 0, 52'hF, "unmapped");
    $display("test pins and rate done");
    send(48'hA5C3_1E0F_9B27, 16'h1B07);
    check("preamble latest", 52'h1B07, {36'h0, preamble_latest});
    rd(ADDR_PREAMBLE, PREAMBLE_BITS, 52'h1B07, "preamble");
    rd(ADDR_DETECT, DETECT_BITS, 52'h3900, "update flags");
    fork
      rd(ADDR_CHANSTAT, WORD_BITS, 52'hA5C3_1E0F_9B27, "frozen status");
      begin
        for (int i = 0; i < 200 && chanstat_frozen !== 1'b1; i++) @(posedge clk);
        check("frozen", 52'h1, {51'h0, chanstat_frozen});
        send(48'h0123_4567_89AB, 16'h1B07);
      end
    join
    send(48'h0123_4567_89AB, 16'h1B07);
    rd(ADDR_CHANSTAT, WORD_BITS, 52'h0123_4567_89AB, "new status");
    $display("test channel status done");
    summarize();
  end
endmodule // receiver_readback_registers_bench
